// ---- hdl/spi_scratch_defines.vh ----
// constants for the serial scratch and memory pass-through block
`ifndef SPI_SCRATCH_DEFINES_VH
`define SPI_SCRATCH_DEFINES_VH

// ----------------------------------------
// frame command bytes
// ----------------------------------------
`define CMD_STATUS 8'hC8
`define CMD_CHECKSUM 8'hD5
`define CMD_CHECKSUM_SUB 8'h81
`define CMD_MESSAGE 8'hF0
`define DIR_WRITE 8'h20
`define DIR_READ 8'h28
`define OP_READ2_FAMILY 6'h18
`define SHORT_FRAME_LEN 3'h4
`define LONG_FRAME_LEN 3'h7
`define FIRST_ANSWER_IDX 3'h3

// ----------------------------------------
// answer codes
// ----------------------------------------
`define REPLY_IDLE 8'h0F
`define REPLY_READY 8'hF0
`define REPLY_DATA 8'hE2
`define REPLY_ERROR 8'hEE
`define FILL_BYTE 8'hFF
`define CHK_BASE 8'hFF

// ----------------------------------------
// scratch offsets, base holds the upper byte
// ----------------------------------------
`define OFS_INPUT_PEAK 10'h037
`define OFS_FEEDBACK_PEAK 10'h03D
`define OFS_FEEDBACK_MAX 10'h047
`define OFS_FEEDBACK_MIN 10'h049
`define OFS_INPUT_MAX 10'h04B
`define OFS_INPUT_MIN 10'h04D
`define OFS_COST 10'h20D
`define OFS_FEEDBACK_RMS 10'h245
`define OFS_INPUT_RMS 10'h247

// ----------------------------------------
// power meter sample kinds and reset values
// ----------------------------------------
`define KIND_PEAK 2'h0
`define KIND_AVG40 2'h1
`define KIND_RMS 2'h2
`define READOUT_RESET 16'h0000
`define TRACK_LOW_START 16'h8000
`define TRACK_HIGH_START 16'h7FFF

// ----------------------------------------
// measurement timing
// ----------------------------------------
`define CLK_KHZ 50000
`define MEAS_PERIOD_MS 340
`define MEAS_WINDOW_MS 40
`define MEAS_PERIOD_CYCLES (`MEAS_PERIOD_MS * `CLK_KHZ)
`define MEAS_WINDOW_CYCLES (`MEAS_WINDOW_MS * `CLK_KHZ)

`endif

// ---- hdl/sample_fifo.v ----
// small first-in first-out buffer for power meter samples
`timescale 1ns/100ps
module sample_fifo #(
  parameter WIDTH = 19,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire mclk, // system clock
  input wire rst, // async reset, active high
  input wire in_valid, // write offer
  output wire in_ready, // room for a word
  input wire [WIDTH-1:0] in_data, // word written
  output wire out_valid, // word available
  input wire out_ready, // reader takes word
  output wire [WIDTH-1:0] out_data // oldest word
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;

  // ----------------------------------------
  // flags
  // ----------------------------------------
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;

  // storage write
  always @(posedge mclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill count
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (do_wr & ~do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd & ~do_wr) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule // sample_fifo

// ---- hdl/spi_scratch_access.v ----
// serial scratch message engine with memory pass-through
`include "spi_scratch_defines.vh"
`timescale 1ns/100ps
module spi_scratch_access #(
  parameter [31:0] PERIOD_CYCLES = `MEAS_PERIOD_CYCLES,
  parameter [31:0] WINDOW_CYCLES = `MEAS_WINDOW_CYCLES,
  parameter FIFO_DEPTH = 8
) (
  input wire mclk, // system clock 50 MHz
  input wire rst, // async reset, active high
  input wire sclk, // serial clock from host
  input wire bus_select_low, // host chip select
  input wire mosi, // serial data from host
  output reg miso, // serial data to host
  output reg miso_en_low, // low while miso is driven
  input wire eeprom_passthrough_select, // high routes bus to memory
  input wire device_restart_low, // restart pin
  output reg mem_sclk, // clock to embedded memory
  output reg mem_select_low, // select to embedded memory
  output reg mem_mosi, // data to embedded memory
  input wire mem_miso, // data from embedded memory
  output reg config_reload, // pulse: reload configuration
  output reg adapt_hold, // high during measurement window
  input wire [15:0] cost_value, // linearity cost from adaptation
  input wire sample_valid, // power meter sample offered
  output wire sample_ready, // sample accepted
  input wire sample_path, // 0 input path, 1 feedback path
  input wire [1:0] sample_kind, // peak, 40us average or rms
  input wire [15:0] sample_value // signed sample
);

  localparam [24:0] PERIOD_LAST = PERIOD_CYCLES[24:0] - 25'h1;
  localparam [24:0] WINDOW_LAST = WINDOW_CYCLES[24:0] - 25'h1;

  // pin synchroniser stages: sclk, select, mosi, pass, restart, mem_miso
  reg [5:0] pin_s1;
  reg [5:0] pin_s2;
  reg [5:0] pin_s3;
  wire sclk_s = pin_s2[0];
  wire ssn_s = pin_s2[1];
  wire mosi_s = pin_s2[2];
  wire pass_s = pin_s2[3];
  wire restart_s = pin_s2[4];
  wire mem_miso_s = pin_s2[5];
  wire sclk_rise = pin_s2[0] & ~pin_s3[0];
  wire sclk_fall = ~pin_s2[0] & pin_s3[0];
  wire ssn_rise = pin_s2[1] & ~pin_s3[1];
  wire ssn_fall = ~pin_s2[1] & pin_s3[1];
  reg hold;

  // message engine state
  reg [7:0] frame [0:6];
  reg [2:0] bit_cnt;
  reg [2:0] byte_idx;
  reg [6:0] rx_sh;
  reg [7:0] tx_sh;
  reg [7:0] next_tx;
  reg [7:0] chk_store;
  reg resp_ready;
  reg [7:0] resp_code;
  reg [7:0] resp_addr;
  reg [7:0] resp_msb;
  reg [7:0] resp_lsb;
  wire [7:0] resp_chk;

  // measurement timer and sample stream
  reg [24:0] meas_cnt;
  wire win_first = (meas_cnt == 25'h0);
  wire win_last = (meas_cnt == WINDOW_LAST);
  wire in_window = (meas_cnt < WINDOW_CYCLES[24:0]);
  wire d_valid;
  wire [18:0] d_word;
  wire d_ready = ~(win_first | win_last) & ~hold;
  wire take = d_valid & d_ready;
  wire [127:0] meter_bus;
  wire [143:0] scratch_bus;

  // ----------------------------------------
  // scratch byte decode
  // ----------------------------------------
  function [7:0] scratch_byte;
    input [9:0] a;
    input [143:0] v;
    begin
      case (a)
        `OFS_INPUT_PEAK: scratch_byte = v[143:136];
        `OFS_INPUT_PEAK + 10'h1: scratch_byte = v[135:128];
        `OFS_FEEDBACK_PEAK: scratch_byte = v[127:120];
        `OFS_FEEDBACK_PEAK + 10'h1: scratch_byte = v[119:112];
        `OFS_FEEDBACK_MAX: scratch_byte = v[111:104];
        `OFS_FEEDBACK_MAX + 10'h1: scratch_byte = v[103:96];
        `OFS_FEEDBACK_MIN: scratch_byte = v[95:88];
        `OFS_FEEDBACK_MIN + 10'h1: scratch_byte = v[87:80];
        `OFS_INPUT_MAX: scratch_byte = v[79:72];
        `OFS_INPUT_MAX + 10'h1: scratch_byte = v[71:64];
        `OFS_INPUT_MIN: scratch_byte = v[63:56];
        `OFS_INPUT_MIN + 10'h1: scratch_byte = v[55:48];
        `OFS_COST: scratch_byte = v[47:40];
        `OFS_COST + 10'h1: scratch_byte = v[39:32];
        `OFS_FEEDBACK_RMS: scratch_byte = v[31:24];
        `OFS_FEEDBACK_RMS + 10'h1: scratch_byte = v[23:16];
        `OFS_INPUT_RMS: scratch_byte = v[15:8];
        `OFS_INPUT_RMS + 10'h1: scratch_byte = v[7:0];
        default: scratch_byte = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // pin synchronisers and restart
  // ----------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_s1 <= 6'h12;
      pin_s2 <= 6'h12;
      pin_s3 <= 6'h12;
      hold <= 1'b1;
      config_reload <= 1'b0;
    end else begin
      pin_s1 <= {mem_miso, device_restart_low, eeprom_passthrough_select, mosi, bus_select_low, sclk};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      hold <= ~restart_s;
      config_reload <= restart_s & ~pin_s3[4];
    end
  end

  // memory pass-through routing and miso drive
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_sclk <= 1'b0;
      mem_select_low <= 1'b1;
      mem_mosi <= 1'b0;
      miso <= 1'b1;
      miso_en_low <= 1'b1;
    end else begin
      mem_select_low <= pass_s ? ssn_s : 1'b1;
      mem_sclk <= pass_s & ~ssn_s & sclk_s;
      mem_mosi <= pass_s & mosi_s;
      miso <= pass_s ? mem_miso_s : tx_sh[7];
      miso_en_low <= ssn_s;
    end
  end

  // ----------------------------------------
  // next answer byte
  // ----------------------------------------
  always @* begin
    next_tx = `FILL_BYTE;
    if (byte_idx >= `FIRST_ANSWER_IDX) begin
      case (frame[0])
        `CMD_STATUS: begin
          if (byte_idx == `FIRST_ANSWER_IDX) begin
            next_tx = resp_ready ? `REPLY_READY : `REPLY_IDLE;
          end
        end
        `CMD_CHECKSUM: begin
          if (frame[2] == `DIR_READ && byte_idx == `FIRST_ANSWER_IDX) begin
            next_tx = resp_chk;
          end
        end
        `CMD_MESSAGE: begin
          if (frame[2] == `DIR_READ) begin
            case (byte_idx)
              3'h3: next_tx = resp_code;
              3'h4: next_tx = resp_addr;
              3'h5: next_tx = resp_msb;
              3'h6: next_tx = resp_lsb;
              default: next_tx = `FILL_BYTE;
            endcase
          end
        end
        default: next_tx = `FILL_BYTE;
      endcase
    end
  end

  // write message checksum and response checksum
  wire [9:0] wr_sum = {2'h0, frame[3]} + {2'h0, frame[4]} + {2'h0, frame[5]} + {2'h0, frame[6]};
  wire [7:0] wr_chk = `CHK_BASE - wr_sum[7:0];
  wire [10:0] rsp_sum = {3'h0, `CMD_MESSAGE} + {3'h0, resp_code} + {3'h0, resp_addr}
                        + {3'h0, resp_msb} + {3'h0, resp_lsb};
  assign resp_chk = `CHK_BASE - rsp_sum[7:0];
  wire [9:0] rd_addr = {frame[3][1:0], frame[4]};
  wire frame_ok = ~pass_s & ~hold;
  wire long_wr = (frame[0] == `CMD_MESSAGE) && (frame[2] == `DIR_WRITE)
                 && (byte_idx == `LONG_FRAME_LEN);

  // ----------------------------------------
  // serial shift engine
  // ----------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 3'h0;
      byte_idx <= 3'h0;
      rx_sh <= 7'h00;
      tx_sh <= `FILL_BYTE;
    end else if (~frame_ok | ssn_s) begin
      bit_cnt <= 3'h0;
      byte_idx <= 3'h0;
      tx_sh <= `FILL_BYTE;
    end else begin
      if (ssn_fall) begin
        tx_sh <= `FILL_BYTE;
      end
      if (sclk_rise) begin
        rx_sh <= {rx_sh[5:0], mosi_s};
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7 && byte_idx != 3'h7) begin
          byte_idx <= byte_idx + 3'h1;
        end
      end
      if (sclk_fall) begin
        tx_sh <= (bit_cnt == 3'h0) ? next_tx : {tx_sh[6:0], 1'b1};
      end
    end
  end

  // received byte capture
  always @(posedge mclk) begin
    if (frame_ok & ~ssn_s & sclk_rise & (bit_cnt == 3'h7) & (byte_idx != 3'h7)) begin
      frame[byte_idx] <= {rx_sh, mosi_s};
    end
  end

  // ----------------------------------------
  // frame completion and responses
  // ----------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      chk_store <= 8'h00;
      resp_ready <= 1'b0;
      resp_code <= 8'h00;
      resp_addr <= 8'h00;
      resp_msb <= 8'h00;
      resp_lsb <= 8'h00;
    end else if (hold) begin
      chk_store <= 8'h00;
      resp_ready <= 1'b0;
    end else if (ssn_rise & ~pass_s) begin
      if (frame[0] == `CMD_CHECKSUM && frame[1] == `CMD_CHECKSUM_SUB
          && frame[2] == `DIR_WRITE && byte_idx == `SHORT_FRAME_LEN) begin
        chk_store <= frame[3];
      end
      if (long_wr) begin
        resp_ready <= 1'b1;
        resp_addr <= frame[4];
        if (wr_chk == chk_store && frame[3][7:2] == `OP_READ2_FAMILY) begin
          resp_code <= `REPLY_DATA;
          resp_msb <= scratch_byte(rd_addr, scratch_bus);
          resp_lsb <= scratch_byte(rd_addr + 10'h1, scratch_bus);
        end else begin
          resp_code <= `REPLY_ERROR;
          resp_msb <= 8'h00;
          resp_lsb <= 8'h00;
        end
      end
      if (frame[0] == `CMD_MESSAGE && frame[2] == `DIR_READ && byte_idx == `LONG_FRAME_LEN) begin
        resp_ready <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // measurement timer
  // ----------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      meas_cnt <= 25'h0;
      adapt_hold <= 1'b0;
    end else if (hold) begin
      meas_cnt <= 25'h0;
      adapt_hold <= 1'b0;
    end else begin
      meas_cnt <= (meas_cnt == PERIOD_LAST) ? 25'h0 : meas_cnt + 25'h1;
      adapt_hold <= in_window;
    end
  end

  // sample buffer between meter and trackers
  sample_fifo #(
    .WIDTH(19),
    .DEPTH(FIFO_DEPTH),
    .AW(3)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data({sample_path, sample_kind, sample_value}),
    .out_valid(d_valid),
    .out_ready(d_ready),
    .out_data(d_word)
  );

  // ----------------------------------------
  // per path window trackers
  // ----------------------------------------
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : path_g
      reg signed [15:0] trk_peak;
      reg signed [15:0] trk_max;
      reg signed [15:0] trk_min;
      reg signed [15:0] trk_rms;
      reg [15:0] r_peak;
      reg [15:0] r_max;
      reg [15:0] r_min;
      reg [15:0] r_rms;
      wire signed [15:0] v = d_word[15:0];
      wire mine = take & in_window & (d_word[18] == p);
      // track within window, publish at its end
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          trk_peak <= `TRACK_LOW_START;
          trk_max <= `TRACK_LOW_START;
          trk_min <= `TRACK_HIGH_START;
          trk_rms <= `READOUT_RESET;
          r_peak <= `READOUT_RESET;
          r_max <= `READOUT_RESET;
          r_min <= `READOUT_RESET;
          r_rms <= `READOUT_RESET;
        end else if (hold | win_first) begin
          trk_peak <= `TRACK_LOW_START;
          trk_max <= `TRACK_LOW_START;
          trk_min <= `TRACK_HIGH_START;
        end else if (win_last) begin
          r_peak <= trk_peak;
          r_max <= trk_max;
          r_min <= trk_min;
          r_rms <= trk_rms;
        end else if (mine) begin
          case (d_word[17:16])
            `KIND_PEAK: if (v > trk_peak) trk_peak <= v;
            `KIND_AVG40: begin
              if (v > trk_max) trk_max <= v;
              if (v < trk_min) trk_min <= v;
            end
            `KIND_RMS: trk_rms <= v;
            default: trk_rms <= trk_rms;
          endcase
        end
      end
      assign meter_bus[p*64 +: 64] = {r_peak, r_max, r_min, r_rms};
    end
  endgenerate

  // scratch image, input path is index 0
  assign scratch_bus = {meter_bus[63:48], meter_bus[127:112], meter_bus[111:96], meter_bus[95:80],
                        meter_bus[47:32], meter_bus[31:16], cost_value, meter_bus[79:64], meter_bus[15:0]};

endmodule // spi_scratch_access

// ---- dv/spi_scratch_props.sv ----
// assertions on the ports of the serial scratch block
`timescale 1ns/100ps
module spi_scratch_props #(
  parameter [31:0] PERIOD_CYCLES = 400,
  parameter [31:0] WINDOW_CYCLES = 50
) (
  input wire mclk, // system clock
  input wire rst, // async reset
  input wire sclk, // host clock
  input wire bus_select_low, // host select
  input wire eeprom_passthrough_select, // memory route
  input wire device_restart_low, // restart pin
  input wire miso_en_low, // miso enable
  input wire mem_sclk, // memory clock
  input wire mem_select_low, // memory select
  input wire config_reload, // reload pulse
  input wire adapt_hold // window flag
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  reg [31:0] hold_cnt;
  reg [31:0] per_cnt;
  reg hold_q;
  reg seen;
  // -------------------------------
  // window length and spacing counters
  // -------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_cnt <= 32'h0;
      per_cnt <= 32'h0;
      hold_q <= 1'b0;
      seen <= 1'b0;
    end else begin
      hold_cnt <= adapt_hold ? hold_cnt + 32'h1 : 32'h0;
      per_cnt <= (adapt_hold && !hold_q) ? 32'h1 : per_cnt + 32'h1;
      hold_q <= adapt_hold;
      seen <= !device_restart_low ? 1'b0 : (seen | (adapt_hold & !hold_q));
    end
  end
  // -------------------------------
  // assertions
  // -------------------------------
  en_on_a: assert property (!bus_select_low [*4] |-> !miso_en_low)
    else $error("miso not enabled while selected");
  en_off_a: assert property (bus_select_low [*4] |-> miso_en_low)
    else $error("miso enabled while deselected");
  mem_idle_a: assert property (!eeprom_passthrough_select [*4] |-> mem_select_low && !mem_sclk)
    else $error("memory pins active outside pass-through");
  mem_route_a: assert property (eeprom_passthrough_select [*6] |->
    mem_select_low == $past(bus_select_low, 3) && mem_sclk == $past(sclk, 3))
    else $error("memory pins do not follow host pins");
  reload_pulse_a: assert property (config_reload |=> !config_reload)
    else $error("reload pulse longer than one cycle");
  reload_cause_a: assert property (config_reload |-> $past(device_restart_low, 1) && $past(device_restart_low, 2))
    else $error("reload without restart pin high");
  hold_len_a: assert property (disable iff (rst || !device_restart_low)
    (!adapt_hold && hold_q) |-> hold_cnt == WINDOW_CYCLES)
    else $error("window length wrong");
  hold_period_a: assert property (disable iff (rst || !device_restart_low)
    (adapt_hold && !hold_q && seen) |-> per_cnt == PERIOD_CYCLES)
    else $error("window spacing wrong");
  cover property (adapt_hold && !hold_q);
  cover property (config_reload);
  cover property (mem_sclk);
endmodule // spi_scratch_props
bind spi_scratch_access spi_scratch_props #(.PERIOD_CYCLES(PERIOD_CYCLES), .WINDOW_CYCLES(WINDOW_CYCLES)) u_props (
  .mclk(mclk), .rst(rst), .sclk(sclk), .bus_select_low(bus_select_low),
  .eeprom_passthrough_select(eeprom_passthrough_select), .device_restart_low(device_restart_low),
  .miso_en_low(miso_en_low), .mem_sclk(mem_sclk), .mem_select_low(mem_select_low),
  .config_reload(config_reload), .adapt_hold(adapt_hold));

// ---- dv/host_master.sv ----
// serial bus master standing in for the host controller
`timescale 1ns/100ps
module host_master #(
  parameter HALF = 4,
  parameter PASS_HALF = 10
) (
  input wire mclk, // system clock
  input wire miso, // data from device
  output reg sclk, // serial clock
  output reg bus_select_low, // chip select
  output reg mosi, // serial data
  output reg eeprom_passthrough_select // memory route
);
  // half period in mclk; slower while routed to memory for the round trip
  int half = HALF;
  // idle pins
  initial begin
    sclk = 1'b0;
    bus_select_low = 1'b1;
    mosi = 1'b0;
    eeprom_passthrough_select = 1'b0;
  end
  // route the bus to memory or back to messages
  task set_pass(input logic on);
    @(negedge mclk);
    eeprom_passthrough_select = on;
    half = on ? PASS_HALF : HALF;
    repeat (8) @(negedge mclk);
  endtask
  // one frame of n bytes, msb first, sample on rise
  task xfer(input int n, input logic [55:0] tx, output logic [55:0] rx);
    int i;
    rx = 56'h0;
    @(negedge mclk);
    bus_select_low = 1'b0;
    for (i = 8 * n - 1; i >= 0; i--) begin
      mosi = tx[i];
      repeat (half) @(negedge mclk);
      sclk = 1'b1;
      rx[i] = miso;
      repeat (half) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (half) @(negedge mclk);
    bus_select_low = 1'b1;
    mosi = ~mosi; // released line shows no stale bit
    repeat (8) @(negedge mclk);
  endtask
endmodule // host_master

// ---- dv/tb_spi_scratch_access.sv ----
// self-checking bench for the serial scratch block
`timescale 1ns/100ps
`include "spi_scratch_defines.vh"
`define CHK(nm, e, g) begin checks_done++; if ((e) !== (g)) begin \
  $display("wrong value %s expected %h seen %h", nm, e, g); n_mismatch++; end end
module tb_spi_scratch_access;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg device_restart_low = 1'b1;
  reg mem_miso = 1'b0;
  reg [15:0] cost_value = 16'hEA68;
  reg sample_valid = 1'b0;
  reg sample_path = 1'b0;
  reg [1:0] sample_kind = 2'h0;
  reg [15:0] sample_value = 16'h0000;
  reg sclk_q = 1'b0;
  wire sclk, bus_select_low, mosi, miso, miso_en_low, eeprom_passthrough_select;
  wire mem_sclk, mem_select_low, mem_mosi, config_reload, adapt_hold, sample_ready;
  int n_mismatch = 0;
  int checks_done = 0;
  int reloads = 0;
  int falls = 0;
  int k;
  logic [55:0] rx;
  logic [15:0] val;
  int acc;
  logic [23:0] mem_hdr = 24'h0;
  logic [7:0] mem_stat = 8'h0C;
  logic rd_stat = 1'b0;
  logic [9:0] radr [5] = '{10'h037, 10'h04B, 10'h04D, 10'h247, 10'h245};
  logic [15:0] rexp [5] = '{16'h2000, 16'h0300, 16'h0100, 16'h0500, 16'hFA00};
  always #10 mclk = ~mclk;
  spi_scratch_access #(.PERIOD_CYCLES(32'd25000), .WINDOW_CYCLES(32'd50)) dut (
    .mclk(mclk), .rst(rst), .sclk(sclk), .bus_select_low(bus_select_low), .mosi(mosi),
    .miso(miso), .miso_en_low(miso_en_low), .eeprom_passthrough_select(eeprom_passthrough_select),
    .device_restart_low(device_restart_low), .mem_sclk(mem_sclk), .mem_select_low(mem_select_low),
    .mem_mosi(mem_mosi), .mem_miso(mem_miso), .config_reload(config_reload), .adapt_hold(adapt_hold),
    .cost_value(cost_value), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_path(sample_path), .sample_kind(sample_kind), .sample_value(sample_value));
  host_master host (.mclk(mclk), .miso(miso), .sclk(sclk), .bus_select_low(bus_select_low),
    .mosi(mosi), .eeprom_passthrough_select(eeprom_passthrough_select));
  // memory: header captured on rise; status opcode answers one byte, reads give 3C, 3D, ...
  always @(negedge mclk) begin
    sclk_q <= mem_sclk;
    if (config_reload === 1'b1) reloads <= reloads + 1;
    if (mem_select_low) begin
      falls <= 0;
      rd_stat <= 1'b0;
      mem_miso <= ~mem_miso;
    end else if (!sclk_q && mem_sclk) begin
      if (falls < 24) mem_hdr <= {mem_hdr[22:0], mem_mosi};
    end else if (sclk_q && !mem_sclk) begin
      falls <= falls + 1;
      if (falls == 7) rd_stat <= (mem_hdr[7:0] == 8'h05);
      if (falls >= 7 && falls < 15 && (falls == 7 ? mem_hdr[7:0] == 8'h05 : rd_stat)) mem_miso <= mem_stat[14 - falls];
      else if (falls >= 23) mem_miso <= mem_bit(falls - 23);
    end
  end
  function logic mem_bit(input int j);
    logic [7:0] b;
    b = 8'h3C + 8'(j / 8);
    return b[7 - j % 8];
  endfunction
  task results;
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // poll status until the wanted code shows
  task poll(input logic [7:0] want);
    int i;
    for (i = 0; i < 20; i++) begin
      host.xfer(4, 56'hC8002800, rx);
      if (rx[7:0] === want) break;
    end
    `CHK("status", want, rx[7:0])
    if (rx[7:0] !== want) results;
  endtask
  // checksummed two-byte scratch read
  task sread(input logic [9:0] adr, output logic [15:0] v);
    logic [7:0] op;
    logic [7:0] s;
    op = {`OP_READ2_FAMILY, adr[9:8]};
    s = 8'hFF - (op + adr[7:0]);
    host.xfer(4, {24'h0, 24'hD58120, s}, rx);
    host.xfer(7, {24'hF00020, op, adr[7:0], 16'h0}, rx);
    poll(`REPLY_READY);
    host.xfer(7, 56'hF0002800000000, rx);
    `CHK("code", `REPLY_DATA, rx[31:24])
    `CHK("echo", adr[7:0], rx[23:16])
    v = rx[15:0];
    s = 8'hFF - (8'hF0 + `REPLY_DATA + rx[23:16] + rx[15:8] + rx[7:0]);
    host.xfer(4, 56'hD5812800, rx);
    `CHK("sum", s, rx[7:0])
  endtask
  // offer one power meter sample
  task push(input logic p, input logic [1:0] kd, input logic [15:0] v);
    sample_path = p;
    sample_kind = kd;
    sample_value = v;
    sample_valid = 1'b1;
    for (k = 0; k < 20 && sample_ready !== 1'b1; k++) @(negedge mclk);
    if (k == 20) begin n_mismatch++; results; end
    @(negedge mclk);
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    `CHK("miso_en_low", 1'b1, miso_en_low)
    `CHK("mem_select_low", 1'b1, mem_select_low)
    `CHK("adapt_hold", 1'b0, adapt_hold)
    `CHK("sample_ready", 1'b1, sample_ready)
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    repeat (20) @(negedge mclk);
    `CHK("reloads", 0, reloads)
    $display("test reset done");
    poll(`REPLY_IDLE);
    acc = 0;
    for (int j = 0; j < 2; j++) begin
      sread(`OFS_COST, val);
      `CHK("cost", 16'hEA68, val)
      acc += $signed(val);
    end
    `CHK("cost average", -5528, acc / 2)
    poll(`REPLY_IDLE);
    $display("test cost read done");
    host.xfer(4, 56'hD5812000, rx);
    host.xfer(7, 56'hF00020620D0000, rx);
    poll(`REPLY_READY);
    host.xfer(7, 56'hF0002800000000, rx);
    `CHK("bad code", `REPLY_ERROR, rx[31:24])
    `CHK("bad data", 16'h0000, rx[15:0])
    host.xfer(4, 56'hD5812090, rx);
    host.xfer(7, 56'hF00020620D0000, rx);
    device_restart_low = 1'b0;
    repeat (6) @(negedge mclk);
    device_restart_low = 1'b1;
    repeat (10) @(negedge mclk);
    `CHK("reloads", 1, reloads)
    host.xfer(4, 56'hC8002800, rx);
    `CHK("after restart", `REPLY_IDLE, rx[7:0])
    $display("test checksum and restart done");
    host.set_pass(1'b1);
    host.xfer(6, 56'h00030010000000, rx);
    `CHK("mem bytes", 24'h3C3D3E, rx[23:0])
    `CHK("mem header", 24'h030010, mem_hdr)
    host.xfer(1, 56'h06, rx);
    host.xfer(2, 56'h010C, rx);
    host.xfer(2, 56'h0500, rx);
    `CHK("lock bits", 2'b11, rx[3:2])
    host.set_pass(1'b0);
    $display("test pass-through done");
    for (k = 0; k < 30000 && adapt_hold !== 1'b1; k++) @(negedge mclk);
    if (adapt_hold !== 1'b1) begin n_mismatch++; results; end
    push(1'b0, `KIND_PEAK, 16'h1234);
    push(1'b0, `KIND_PEAK, 16'h2000);
    push(1'b0, `KIND_AVG40, 16'h0100);
    push(1'b0, `KIND_AVG40, 16'h0300);
    push(1'b0, `KIND_AVG40, 16'h0200);
    push(1'b0, `KIND_RMS, 16'h0500);
    push(1'b1, `KIND_RMS, 16'hFA00);
    sample_valid = 1'b0;
    for (k = 0; k < 100 && adapt_hold !== 1'b0; k++) @(negedge mclk);
    if (adapt_hold !== 1'b0) begin n_mismatch++; results; end
    for (int j = 0; j < 5; j++) begin
      sread(radr[j], val);
      `CHK("readout", rexp[j], val)
    end
    $display("test power readouts done");
    results;
  end
endmodule // tb_spi_scratch_access
